// *** shared/nbu_pkg.sv ***
// constants shared by both ends of the nine-bit serial link
// assumes one clock (mclk) at every end and a point-to-point line pair
package nbu_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL_HIGH  = 8'hF9;
	localparam logic [7:0] IDX_CTRL_LOW   = 8'hFA;
	localparam logic [7:0] IDX_DATA       = 8'hFB;
	localparam logic [7:0] IDX_BAUD       = 8'hFC;

	// serial_ctrl_high field positions
	localparam int         CH_MODE_HI     = 7;
	localparam int         CH_MODE_LO     = 6;
	localparam int         CH_MCE         = 5;
	localparam int         CH_RE          = 4;
	localparam int         CH_TB8         = 3;
	localparam int         CH_RB8         = 2;
	localparam int         CH_RXPEND      = 0;
	// serial_ctrl_low field positions
	localparam int         CL_TXPEND      = 0;

	// reset values
	localparam logic [7:0] CTRL_HIGH_RST  = 8'h00;
	localparam logic [7:0] CTRL_LOW_RST   = 8'h00;
	localparam logic [7:0] BAUD_RST       = 8'h00;
	localparam logic [7:0] DATA_RST       = 8'h00;

	// operating modes
	localparam logic [1:0] MODE_SHIFT     = 2'h0;
	localparam logic [1:0] MODE_8BIT      = 2'h1;
	localparam logic [1:0] MODE_FIXED9    = 2'h2;
	localparam logic [1:0] MODE_VAR9      = 2'h3;

	// frame timing
	localparam int         OVERSAMPLE     = 16;
	localparam logic [3:0] PH_MID         = 4'h7;
	localparam logic [3:0] PH_LAST        = 4'hF;
	localparam logic [3:0] LAST_BIT_NINE  = 4'hA;
	localparam logic [3:0] LAST_BIT_EIGHT = 4'h9;
	localparam logic [3:0] NINTH_SLOT     = 4'h8;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_BITS  = 4'h4,
		RX_STOP  = 4'h8
	} nbu_rx_state_t;

endpackage

// *** shared/nbu_if.sv ***
// serial line pair between the uart end and a partner node
// assumes both ends share mclk; lines idle high
`timescale 1ns/1ps
interface nbu_if;
	logic devTx;
	logic nodeTx;

	modport dev
	(
		output devTx,
		input  nodeTx
	);

	modport node
	(
		input  devTx,
		output nodeTx
	);
endinterface

// *** hw/nbu_device.sv ***
// nine-bit uart with multiprocessor filter, registers on classic wishbone
// assumes serial input is synchronous to mclk; fu equals mclk
`timescale 1ns/1ps
module nbu_device #(
	parameter int DIV_W = 8
)(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// wishbone slave
	input  wire logic        wbCyc,
	input  wire logic        wbStb,
	input  wire logic        wbWe,
	input  wire logic [9:0]  wbAdr,
	input  wire logic [3:0]  wbSel,
	input  wire logic [31:0] wbDatW,
	output logic      [31:0] wbDatR,
	output logic             wbAck,
	// serial line
	nbu_if.dev               link
);

	logic [1:0]       mode_q;
	logic             mce_q;
	logic             re_q;
	logic             tb8_q;
	logic             rb8_q;
	logic             rxPend_q;
	logic             txPend_q;
	logic [7:0]       baud_q;
	logic [7:0]       rxData_q;
	logic             ack_q;
	logic [31:0]      datR_q;
	logic [DIV_W-1:0] divCnt_q;
	logic             txBusy_q;
	logic [10:0]      txShift_q;
	logic [3:0]       txBit_q;
	logic [3:0]       txPh_q;
	logic             txPin_q;
	nbu_pkg::nbu_rx_state_t rxState_q;
	logic [3:0]       rxPh_q;
	logic [3:0]       rxBit_q;
	logic [7:0]       rxShift_q;
	logic [7:0]       ctrlHigh;

	// bus decode
	wire       reqHit  = wbCyc & wbStb;
	wire [7:0] regIdx  = wbAdr[9:2];
	wire       selHigh = (regIdx == nbu_pkg::IDX_CTRL_HIGH);
	wire       selLow  = (regIdx == nbu_pkg::IDX_CTRL_LOW);
	wire       selData = (regIdx == nbu_pkg::IDX_DATA);
	wire       selBaud = (regIdx == nbu_pkg::IDX_BAUD);
	// write lands on the edge the master sees ack
	wire       wrNow   = reqHit & wbWe & ack_q & wbSel[0];
	wire       wrHigh  = wrNow & selHigh;
	wire       wrLow   = wrNow & selLow;
	wire       wrBaud  = wrNow & selBaud;

	always_comb
	begin
		ctrlHigh                            = 8'h00;
		ctrlHigh[nbu_pkg::CH_MODE_HI]       = mode_q[1];
		ctrlHigh[nbu_pkg::CH_MODE_LO]       = mode_q[0];
		ctrlHigh[nbu_pkg::CH_MCE]           = mce_q;
		ctrlHigh[nbu_pkg::CH_RE]            = re_q;
		ctrlHigh[nbu_pkg::CH_TB8]           = tb8_q;
		ctrlHigh[nbu_pkg::CH_RB8]           = rb8_q;
		ctrlHigh[nbu_pkg::CH_RXPEND]        = rxPend_q;
	end

	wire [7:0] ctrlLow = {7'h00, txPend_q};
	wire [7:0] rdByte  = selHigh ? ctrlHigh :
	                     selLow  ? ctrlLow  :
	                     selData ? rxData_q :
	                     selBaud ? baud_q   : 8'h00;

	// mode decode
	wire modeOn  = (mode_q != nbu_pkg::MODE_SHIFT);
	wire mode8   = (mode_q == nbu_pkg::MODE_8BIT);
	wire modeFix = (mode_q == nbu_pkg::MODE_FIXED9);

	// oversampling tick: every clock in fixed mode, else every divisor+1
	wire [DIV_W-1:0] divLimit = modeFix ? '0 : baud_q[DIV_W-1:0];
	wire             tick     = (divCnt_q >= divLimit);

	// transmitter
	wire        txStart   = wrNow & selData & modeOn & ~txBusy_q;
	wire        txNinth   = mode8 ? 1'b1 : tb8_q;
	wire [10:0] txFrame   = {1'b1, txNinth, wbDatW[7:0], 1'b0};
	wire [3:0]  txLast    = mode8 ? nbu_pkg::LAST_BIT_EIGHT : nbu_pkg::LAST_BIT_NINE;
	wire        txBitEnd  = txBusy_q & tick & (txPh_q == nbu_pkg::PH_LAST);
	wire [3:0]  txBitNext = txBit_q + 4'h1;
	wire        txStopBeg = txBitEnd & (txBitNext == txLast) & (txBit_q != txLast);

	// receiver
	wire rxPin    = link.nodeTx;
	wire rxMid    = tick & (rxPh_q == nbu_pkg::PH_MID);
	wire frameEnd = (rxState_q == nbu_pkg::RX_BITS) & rxMid & (rxBit_q == nbu_pkg::NINTH_SLOT);
	// filter: ninth bit in nine-bit modes, stop bit in mode 1
	wire accept   = frameEnd & (~mce_q | rxPin);

	// bus slave: one wait state, ack lasts one cycle
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ack_q  <= 1'b0;
			datR_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= reqHit & ~ack_q;
			if (reqHit & ~ack_q)
				datR_q <= {24'h00_0000, rdByte};
		end
	end

	// control registers; hardware sets win over software clears
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			mode_q   <= nbu_pkg::CTRL_HIGH_RST[nbu_pkg::CH_MODE_HI:nbu_pkg::CH_MODE_LO];
			mce_q    <= nbu_pkg::CTRL_HIGH_RST[nbu_pkg::CH_MCE];
			re_q     <= nbu_pkg::CTRL_HIGH_RST[nbu_pkg::CH_RE];
			tb8_q    <= nbu_pkg::CTRL_HIGH_RST[nbu_pkg::CH_TB8];
			rb8_q    <= nbu_pkg::CTRL_HIGH_RST[nbu_pkg::CH_RB8];
			rxPend_q <= nbu_pkg::CTRL_HIGH_RST[nbu_pkg::CH_RXPEND];
			txPend_q <= nbu_pkg::CTRL_LOW_RST[nbu_pkg::CL_TXPEND];
			baud_q   <= nbu_pkg::BAUD_RST;
			rxData_q <= nbu_pkg::DATA_RST;
		end
		else
		begin
			if (wrHigh)
			begin
				mode_q <= wbDatW[nbu_pkg::CH_MODE_HI:nbu_pkg::CH_MODE_LO];
				mce_q  <= wbDatW[nbu_pkg::CH_MCE];
				re_q   <= wbDatW[nbu_pkg::CH_RE];
				tb8_q  <= wbDatW[nbu_pkg::CH_TB8];
			end
			if (frameEnd)
				rb8_q <= rxPin;
			else if (wrHigh)
				rb8_q <= wbDatW[nbu_pkg::CH_RB8];
			if (accept)
				rxPend_q <= 1'b1;
			else if (wrHigh)
				rxPend_q <= wbDatW[nbu_pkg::CH_RXPEND];
			if (txStopBeg)
				txPend_q <= 1'b1;
			else if (wrLow)
				txPend_q <= wbDatW[nbu_pkg::CL_TXPEND];
			if (wrBaud)
				baud_q <= wbDatW[7:0];
			if (accept)
				rxData_q <= rxShift_q;
		end
	end

	// baud prescaler
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			divCnt_q <= '0;
		else if (tick)
			divCnt_q <= '0;
		else
			divCnt_q <= divCnt_q + 1'b1;
	end

	// transmit shifter; start bit may be short by under one tick
	// since the prescaler is shared and not realigned on load
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			txBusy_q  <= 1'b0;
			txShift_q <= 11'h7FF;
			txBit_q   <= 4'h0;
			txPh_q    <= 4'h0;
			txPin_q   <= 1'b1;
		end
		else if (txStart)
		begin
			txBusy_q  <= 1'b1;
			txShift_q <= txFrame;
			txBit_q   <= 4'h0;
			txPh_q    <= 4'h0;
			txPin_q   <= 1'b0;
		end
		else if (txBusy_q & tick)
		begin
			txPh_q <= txPh_q + 4'h1;
			if (txBitEnd)
			begin
				if (txBit_q == txLast)
					txBusy_q <= 1'b0;
				else
				begin
					txShift_q <= {1'b1, txShift_q[10:1]};
					txPin_q   <= txShift_q[1];
					txBit_q   <= txBitNext;
				end
			end
		end
	end

	// receive sequencer; phase free-runs so mid-bit recurs every 16 ticks
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rxState_q <= nbu_pkg::RX_IDLE;
			rxPh_q    <= 4'h0;
			rxBit_q   <= 4'h0;
			rxShift_q <= 8'h00;
		end
		else
		begin
			if (tick)
				rxPh_q <= rxPh_q + 4'h1;
			case (rxState_q)
				nbu_pkg::RX_IDLE:
				begin
					if (re_q & modeOn & ~rxPin)
					begin
						rxState_q <= nbu_pkg::RX_START;
						rxPh_q    <= 4'h0;
						rxBit_q   <= 4'h0;
					end
				end
				nbu_pkg::RX_START:
				begin
					if (rxMid)
						rxState_q <= rxPin ? nbu_pkg::RX_IDLE : nbu_pkg::RX_BITS;
				end
				nbu_pkg::RX_BITS:
				begin
					if (rxMid)
					begin
						rxBit_q <= rxBit_q + 4'h1;
						if (rxBit_q != nbu_pkg::NINTH_SLOT)
							rxShift_q <= {rxPin, rxShift_q[7:1]};
						else
							rxState_q <= mode8 ? nbu_pkg::RX_IDLE : nbu_pkg::RX_STOP;
					end
				end
				nbu_pkg::RX_STOP:
				begin
					if (rxMid)
						rxState_q <= nbu_pkg::RX_IDLE;
				end
				default:
					rxState_q <= nbu_pkg::RX_IDLE;
			endcase
		end
	end

	assign wbAck      = ack_q;
	assign wbDatR     = datR_q;
	assign link.devTx = txPin_q;

endmodule // nbu_device

// *** hw/nbu_node.sv ***
// partner node on the serial line: sends addressed messages, filters as a slave
// assumes the node bit time matches the uart end's configured rate
`timescale 1ns/1ps
module nbu_node #(
	parameter int CLKS_PER_BIT = 16
)(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// send side
	input  wire logic       sendValid,
	input  wire logic [7:0] sendByte,
	input  wire logic       sendIsAddr,
	output logic            sendReady,
	output logic            sendRefused,
	// receive side
	input  wire logic [7:0] ownAddr,
	output logic            rxValid,
	output logic [7:0]      rxByte,
	output logic            rxIsAddr,
	output logic            addressed,
	// serial line
	nbu_if.node             link
);

	localparam int CW = $clog2(CLKS_PER_BIT);
	localparam logic [CW-1:0] CNT_LAST = CW'(CLKS_PER_BIT - 1);
	localparam logic [CW-1:0] CNT_HALF = CW'(CLKS_PER_BIT / 2 - 1);

	logic          txIdle_q;
	logic [10:0]   txShift_q;
	logic [3:0]    txBit_q;
	logic [CW-1:0] txCnt_q;
	logic          txPin_q;
	logic          target_q;
	logic          refused_q;
	nbu_pkg::nbu_rx_state_t rxState_q;
	logic [CW-1:0] rxCnt_q;
	logic [3:0]    rxBit_q;
	logic [7:0]    rxShift_q;
	logic          mce_q;
	logic          rxValid_q;
	logic [7:0]    rxByte_q;
	logic          rxIsAddr_q;

	// data frames only after an address frame
	wire sendOk  = sendValid & txIdle_q & (sendIsAddr | target_q);
	wire sendBad = sendValid & txIdle_q & ~sendIsAddr & ~target_q;
	wire txTick  = (txCnt_q == CNT_LAST);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			txIdle_q  <= 1'b1;
			txShift_q <= 11'h7FF;
			txBit_q   <= 4'h0;
			txCnt_q   <= '0;
			txPin_q   <= 1'b1;
			target_q  <= 1'b0;
			refused_q <= 1'b0;
		end
		else
		begin
			refused_q <= sendBad;
			if (sendOk)
			begin
				txIdle_q  <= 1'b0;
				txShift_q <= {1'b1, sendIsAddr, sendByte, 1'b0};
				txBit_q   <= 4'h0;
				txCnt_q   <= '0;
				txPin_q   <= 1'b0;
				if (sendIsAddr)
					target_q <= 1'b1;
			end
			else if (~txIdle_q)
			begin
				txCnt_q <= txTick ? '0 : txCnt_q + 1'b1;
				if (txTick)
				begin
					if (txBit_q == nbu_pkg::LAST_BIT_NINE)
						txIdle_q <= 1'b1;
					else
					begin
						txShift_q <= {1'b1, txShift_q[10:1]};
						txPin_q   <= txShift_q[1];
						txBit_q   <= txBit_q + 4'h1;
					end
				end
			end
		end
	end

	// receiver with slave address filter
	wire rxPin    = link.devTx;
	wire rxMid    = (rxCnt_q == CNT_HALF);
	wire frameEnd = (rxState_q == nbu_pkg::RX_BITS) & rxMid & (rxBit_q == nbu_pkg::NINTH_SLOT);
	wire isMatch  = (rxShift_q == ownAddr);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rxState_q  <= nbu_pkg::RX_IDLE;
			rxCnt_q    <= '0;
			rxBit_q    <= 4'h0;
			rxShift_q  <= 8'h00;
			mce_q      <= 1'b1;
			rxValid_q  <= 1'b0;
			rxByte_q   <= 8'h00;
			rxIsAddr_q <= 1'b0;
		end
		else
		begin
			// one-cycle report, nothing left pending
			rxValid_q <= 1'b0;
			rxCnt_q   <= (rxCnt_q == CNT_LAST) ? '0 : rxCnt_q + 1'b1;
			case (rxState_q)
				nbu_pkg::RX_IDLE:
				begin
					rxCnt_q <= '0;
					if (~rxPin)
					begin
						rxState_q <= nbu_pkg::RX_START;
						rxBit_q   <= 4'h0;
					end
				end
				nbu_pkg::RX_START:
				begin
					if (rxMid)
						rxState_q <= rxPin ? nbu_pkg::RX_IDLE : nbu_pkg::RX_BITS;
				end
				nbu_pkg::RX_BITS:
				begin
					if (rxMid & ~frameEnd)
					begin
						rxShift_q <= {rxPin, rxShift_q[7:1]};
						rxBit_q   <= rxBit_q + 4'h1;
					end
					if (frameEnd)
					begin
						rxState_q <= nbu_pkg::RX_STOP;
						if (rxPin)
						begin
							mce_q      <= ~isMatch;
							rxValid_q  <= 1'b1;
							rxByte_q   <= rxShift_q;
							rxIsAddr_q <= 1'b1;
						end
						else if (~mce_q)
						begin
							rxValid_q  <= 1'b1;
							rxByte_q   <= rxShift_q;
							rxIsAddr_q <= 1'b0;
						end
					end
				end
				nbu_pkg::RX_STOP:
				begin
					if (rxMid)
						rxState_q <= nbu_pkg::RX_IDLE;
				end
				default:
					rxState_q <= nbu_pkg::RX_IDLE;
			endcase
		end
	end

	assign sendReady   = txIdle_q;
	assign sendRefused = refused_q;
	assign rxValid     = rxValid_q;
	assign rxByte      = rxByte_q;
	assign rxIsAddr    = rxIsAddr_q;
	assign addressed   = ~mce_q;
	assign link.nodeTx = txPin_q;

endmodule // nbu_node

// *** sim/nbu_asserts.sv ***
// wire checks on the serial line pair between the uart end and the node
// assumes both lines are sampled on mclk; node bits last 16 clocks
`timescale 1ns/1ps
module nbu_asserts (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// serial lines
	input wire logic devTx,
	input wire logic nodeTx
);
	logic [9:0] devRun_q;
	logic [9:0] nodeRun_q;
	logic       devLast_q;
	logic       nodeLast_q;

	// length of the run each line has held, read at the edge it changes
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			devRun_q   <= 10'h001;
			nodeRun_q  <= 10'h001;
			devLast_q  <= 1'b1;
			nodeLast_q <= 1'b1;
		end
		else
		begin
			devRun_q   <= (devTx != devLast_q) ? 10'h001 : devRun_q + 10'h001;
			nodeRun_q  <= (nodeTx != nodeLast_q) ? 10'h001 : nodeRun_q + 10'h001;
			devLast_q  <= devTx;
			nodeLast_q <= nodeTx;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	idle_high_a: assert property ($fell(rst) |-> devTx && nodeTx)
		else $error("line not idle high after reset");
	node_bit_a: assert property (nodeTx && !nodeLast_q |-> nodeRun_q[3:0] == 4'h0)
		else $error("node low run not whole bits");
	node_stop_a: assert property (!nodeTx && !nodeLast_q |-> nodeRun_q <= 10'h0A0)
		else $error("node line low past frame");
	// a start bit may be short by under one tick, so allow 14 or 15 as well
	dev_grid_a: assert property (devTx && !devLast_q |-> devRun_q[3:0] inside {4'hE, 4'hF, 4'h0})
		else $error("uart low run off bit grid");
	dev_stop_a: assert property (!devTx && !devLast_q |-> devRun_q <= 10'h140)
		else $error("uart line low past frame");
	dev_start_a: assert property (devTx && !devLast_q |-> devRun_q >= 10'h00E)
		else $error("uart low run too short");
	node_hold_a: assert property ($changed(nodeTx) |=> $stable(nodeTx) [*8])
		else $error("node bit too short");
	dev_hold_a: assert property ($changed(devTx) |=> $stable(devTx) [*8])
		else $error("uart bit too short");
endmodule // nbu_asserts

// *** sim/nine_bit_uart_multiproc_tb_top.sv ***
// bench joining the uart end and the node over one line pair
// assumes the node runs 16 clocks a bit; wishbone bus driven here
`timescale 1ns/1ps
module nine_bit_uart_multiproc_tb_top;
	logic        mclk, rst, wbCyc, wbStb, wbWe, wbAck;
	logic [9:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbDatW, wbDatR;
	logic        sendValid, sendIsAddr, sendReady, sendRefused, rxValid, rxIsAddr, addressed;
	logic [7:0]  sendByte, ownAddr, rxByte, rd, b, cfg, mdlData;
	logic [8:0]  bits;
	logic        stopBit, isAddr, accept;
	logic [8:0]  nodeQ[$];
	int          mismatches, checks, cycles, refusedCnt;
	logic [7:0]  regIdx[5] = '{8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'h10};
	logic [7:0]  txCfg[3] = '{8'h88, 8'h80, 8'hC8};
	logic [7:0]  rxCfg[6] = '{8'hB0, 8'hB0, 8'h90, 8'h70, 8'h70, 8'h80};
	logic        rxAddr[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

	nbu_if link();
	nbu_device nbu_device_i (.mclk(mclk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
		.wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .link(link));
	nbu_node #(.CLKS_PER_BIT(16)) nbu_node_i (.mclk(mclk), .rst(rst), .sendValid(sendValid), .sendByte(sendByte),
		.sendIsAddr(sendIsAddr), .sendReady(sendReady), .sendRefused(sendRefused), .ownAddr(ownAddr),
		.rxValid(rxValid), .rxByte(rxByte), .rxIsAddr(rxIsAddr), .addressed(addressed), .link(link));
	nbu_asserts nbu_asserts_i (.mclk(mclk), .rst(rst), .devTx(link.devTx), .nodeTx(link.nodeTx));

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task results;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task wbXfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge mclk);
		{wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'h3, we, idx, 2'h0, 24'h0, wd};
		// ends on wbAck; if ack never comes only the bench timeout ends this wait
		do
			@(posedge mclk);
		while (wbAck !== 1'b1);
		rd = wbDatR[7:0];
		{wbCyc, wbStb} <= 2'h0;
	endtask

	task nodeSend(input logic addr, input logic [7:0] v);
		@(posedge mclk);
		{sendValid, sendIsAddr, sendByte} <= {1'b1, addr, v};
		do
			@(posedge mclk);
		while (sendReady !== 1'b1);
		sendValid <= 1'b0;
	endtask

	function automatic logic lineAt(input bit fromNode);
		return fromNode ? link.nodeTx : link.devTx;
	endfunction

	// sample a frame at bit centres, timed from the falling start edge
	task lineFrame(input bit fromNode, input int bitClk);
		while (lineAt(fromNode) !== 1'b0)
			@(negedge mclk);
		repeat (bitClk / 2) @(negedge mclk);
		check(lineAt(fromNode), 1'b0, "start bit");
		for (int i = 0; i < 9; i++)
		begin
			repeat (bitClk) @(negedge mclk);
			bits[i] = lineAt(fromNode);
		end
		repeat (bitClk) @(negedge mclk);
		stopBit = lineAt(fromNode);
	endtask

	always @(posedge mclk)
	begin
		cycles++;
		if (sendRefused === 1'b1)
			refusedCnt++;
		if (rxValid === 1'b1)
			nodeQ.push_back({rxIsAddr, rxByte});
		if (cycles == 30000)
		begin
			mismatches++;
			results();
		end
	end

	initial
	begin
		{rst, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = {1'b1, 3'h0, 10'h000, 4'h1, 32'h0};
		{sendValid, sendIsAddr, sendByte} = 10'h000;
		void'($urandom(57));
		ownAddr = 8'($urandom);
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		wbXfer(1'b1, 8'h10, 8'hFF);
		for (int i = 0; i < 5; i++)
		begin
			wbXfer(1'b0, regIdx[i], 8'h00);
			check(rd, 8'h00, "reset value");
		end
		// mode 00 is not carried: a data write must not start a frame
		wbXfer(1'b1, nbu_pkg::IDX_DATA, 8'h55);
		repeat (20) @(posedge mclk);
		check(link.devTx, 1'b1, "shift mode idle");
		wbXfer(1'b0, nbu_pkg::IDX_CTRL_LOW, 8'h00);
		check(rd, 8'h00, "shift mode pending");
		// data before any address is refused and the line stays idle
		nodeSend(1'b0, 8'h3C);
		repeat (4) @(posedge mclk);
		check(refusedCnt, 1, "refusal");
		check(link.nodeTx, 1'b1, "idle line");
		for (int j = 0; j < 3; j++)
		begin
			b = (j == 0) ? ownAddr : 8'($urandom);
			if (j == 2)
				wbXfer(1'b1, nbu_pkg::IDX_BAUD, 8'h01);
			wbXfer(1'b1, nbu_pkg::IDX_CTRL_HIGH, txCfg[j]);
			fork
				wbXfer(1'b1, nbu_pkg::IDX_DATA, b);
				lineFrame(1'b0, (j == 2) ? 32 : 16);
			join
			check(bits, {txCfg[j][3], b}, "tx frame");
			check(stopBit, 1'b1, "tx stop");
			if (j < 2)
			begin
				repeat (20) @(posedge mclk);
				check(nodeQ.size(), 1, "node count");
				check(nodeQ.pop_front(), {txCfg[j][3], b}, "node rx");
				check(addressed, 1'b1, "addressed");
			end
			wbXfer(1'b0, nbu_pkg::IDX_CTRL_LOW, 8'h00);
			check(rd, 8'h01, "tx pending");
			wbXfer(1'b1, nbu_pkg::IDX_CTRL_LOW, 8'h00);
		end
		wbXfer(1'b1, nbu_pkg::IDX_BAUD, 8'h00);
		// filter on and off, stop-bit check in mode 01, receiver disabled
		for (int k = 0; k < 6; k++)
		begin
			{cfg, isAddr, b} = {rxCfg[k], rxAddr[k], 8'($urandom)};
			accept = cfg[4] && (isAddr || !cfg[5]);
			if (accept)
				mdlData = b;
			wbXfer(1'b1, nbu_pkg::IDX_CTRL_HIGH, cfg);
			fork
				nodeSend(isAddr, b);
				lineFrame(1'b1, 16);
			join
			check(bits, {isAddr, b}, "node frame");
			wbXfer(1'b0, nbu_pkg::IDX_CTRL_HIGH, 8'h00);
			check(rd, cfg | {5'h0, isAddr && cfg[4], 1'b0, accept}, "rx status");
			wbXfer(1'b0, nbu_pkg::IDX_DATA, 8'h00);
			check(rd, mdlData, "rx data");
		end
		check(refusedCnt, 1, "refusal count");
		results();
	end
endmodule // nine_bit_uart_multiproc_tb_top
